/* core/rmii_port_interface.sv */
/*
 * Physical-layer side of an eight-port reduced media independent interface.
 * Transmit di-bits and enables are captured per port and handed to the line
 * transmitters; receive di-bits, valid and error from the line receivers are
 * launched toward the controllers with per-port output enables.
 * Assumes clk_sys_i is the shared reference clock and that the line side
 * signals are synchronous to it, except the raw carrier detect.
 */
module rmii_port_interface #(
   parameter int unsigned NUM_PORTS = rmii_port_pkg::PORT_COUNT
) (
   input  wire logic                                            clk_sys_i,
   input  wire logic                                            nrst_i,
   // Mode controls.
   input  wire logic                                            isolate_i,
   input  wire logic                                            power_down_i,
   // Controller transmit side.
   input  wire logic [NUM_PORTS*rmii_port_pkg::DIBIT_WIDTH-1:0] port_tx_dibit_i,
   input  wire logic [NUM_PORTS-1:0]                            port_tx_enable_i,
   // Line transmitter side.
   output logic [NUM_PORTS*rmii_port_pkg::DIBIT_WIDTH-1:0]      line_tx_dibit_o,
   output logic [NUM_PORTS-1:0]                                 line_tx_active_o,
   // Line receiver side.
   input  wire logic [NUM_PORTS*rmii_port_pkg::DIBIT_WIDTH-1:0] line_rx_dibit_i,
   input  wire logic [NUM_PORTS-1:0]                            line_rx_carrier_i,
   input  wire logic [NUM_PORTS-1:0]                            line_rx_error_i,
   // Controller receive side, three-state as value plus enable.
   output logic [NUM_PORTS*rmii_port_pkg::DIBIT_WIDTH-1:0]      port_rx_dibit_o,
   output logic [NUM_PORTS-1:0]                                 port_rx_valid_o,
   output logic [NUM_PORTS-1:0]                                 port_rx_error_o,
   output logic [NUM_PORTS-1:0]                                 port_rx_oe_o,
   output logic [NUM_PORTS-1:0]                                 port_link_busy_o
);
   import rmii_port_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Reset release.
   ////////////////////////////////////////////////////////////////////////////

   logic nrst_sync;

   // Both edges of the logic share this copy of the reset.
   rmii_reset_sync #(
      .STAGES (RESET_SYNC_STAGES)
   ) u_reset_sync (
      .clk_i       (clk_sys_i),
      .nrst_i      (nrst_i),
      .nrst_sync_o (nrst_sync)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Mode capture.
   ////////////////////////////////////////////////////////////////////////////

   logic isolate_q;
   logic power_down_q;
   wire  rx_float;

   // Mode pins are interface inputs and are taken on the rising edge.
   // A mode change therefore reaches the receive enables at the next falling
   // edge, half a cycle after capture, never in the middle of a launch.
   always_ff @(posedge clk_sys_i or negedge nrst_sync) begin
      if (!nrst_sync) begin
         isolate_q    <= FLAG_RESET;
         power_down_q <= FLAG_RESET;
      end else begin
         isolate_q    <= isolate_i;
         power_down_q <= power_down_i;
      end
   end

   // The receive pins float in isolation or power-down; reset is added below.
   assign rx_float = isolate_q | power_down_q;

   ////////////////////////////////////////////////////////////////////////////
   // Per-port lanes.
   ////////////////////////////////////////////////////////////////////////////

   genvar p;
   generate
      for (p = 0; p < NUM_PORTS; p++) begin : g_port
         localparam int unsigned LO = p * DIBIT_WIDTH;

         logic [DIBIT_WIDTH-1:0] tx_dibit_q;
         logic                   tx_enable_q;
         logic [DIBIT_WIDTH-1:0] rx_dibit_q;
         logic                   rx_error_q;
         logic                   rx_valid_q;
         logic                   rx_oe_q;
         link_state_t            state;
         link_state_t            next_state;
         wire                    tx_send;
         wire [DIBIT_WIDTH-1:0]  next_tx_dibit;
         wire [DIBIT_WIDTH-1:0]  next_rx_dibit;
         wire                    next_rx_error;
         wire                    next_rx_oe;
         logic [DIBIT_WIDTH-1:0] line_dibit_q;
         logic                   line_active_q;
         logic                   busy_q;

         // Transmit di-bit and enable are captured together each rising edge.
         // They stay paired, so a di-bit is never sent under the wrong enable.
         always_ff @(posedge clk_sys_i or negedge nrst_sync) begin
            if (!nrst_sync) begin
               tx_dibit_q  <= DIBIT_RESET;
               tx_enable_q <= FLAG_RESET;
            end else begin
               tx_dibit_q  <= port_tx_dibit_i[LO +: DIBIT_WIDTH];
               tx_enable_q <= port_tx_enable_i[p];
            end
         end

         // The transmitter runs only while enabled and not powered down.
         assign tx_send       = tx_enable_q & ~power_down_q;
         assign next_tx_dibit = tx_send ? tx_dibit_q : DIBIT_RESET;

         // One di-bit per cycle goes to the line transmitter.
         // Local flops feed the output slices, so each output bit has a single writer.
         always_ff @(posedge clk_sys_i or negedge nrst_sync) begin
            if (!nrst_sync) begin
               line_dibit_q  <= DIBIT_RESET;
               line_active_q <= FLAG_RESET;
            end else begin
               line_dibit_q  <= next_tx_dibit;
               line_active_q <= tx_send;
            end
         end

         // Receive data is zero outside carrier; errors count only inside it.
         assign next_rx_dibit = line_rx_carrier_i[p] ? line_rx_dibit_i[LO +: DIBIT_WIDTH] : DIBIT_RESET;
         assign next_rx_error = line_rx_carrier_i[p] & line_rx_error_i[p];
         assign next_rx_oe    = ~rx_float;

         // Receive data, error and enable are launched on the falling edge.
         always_ff @(negedge clk_sys_i or negedge nrst_sync) begin
            if (!nrst_sync) begin
               rx_dibit_q <= DIBIT_RESET;
               rx_error_q <= FLAG_RESET;
               rx_oe_q    <= FLAG_RESET;
            end else begin
               rx_dibit_q <= next_rx_dibit;
               rx_error_q <= next_rx_error;
               rx_oe_q    <= next_rx_oe;
            end
         end

         // Valid is set at once by carrier and cleared on a falling edge.
         // The set is asynchronous so a controller sees carrier before the next edge;
         // set beats the clear, so carrier present at a falling edge is never dropped.
         always_ff @(negedge clk_sys_i or negedge nrst_sync or posedge line_rx_carrier_i[p]) begin
            if (!nrst_sync) begin
               rx_valid_q <= FLAG_RESET;
            end else if (line_rx_carrier_i[p]) begin
               rx_valid_q <= 1'b1;
            end else begin
               rx_valid_q <= 1'b0;
            end
         end

         // Link activity tracks power state, carrier and transmit enable for status.
         // Power-down sends a port to the off state from anywhere, so a powered-down
         // port never reports activity even if its enable is still high.
         always_comb begin
            next_state = state;
            case (state)
               LINK_OFF: begin
                  if (!power_down_q) begin
                     next_state = LINK_IDLE;
                  end
               end
               LINK_IDLE: begin
                  if (power_down_q) begin
                     next_state = LINK_OFF;
                  end else if (rx_valid_q || tx_enable_q) begin
                     next_state = LINK_BUSY;
                  end
               end
               LINK_BUSY: begin
                  if (power_down_q) begin
                     next_state = LINK_OFF;
                  end else if (!rx_valid_q && !tx_enable_q) begin
                     next_state = LINK_IDLE;
                  end
               end
               default: begin
                  next_state = LINK_OFF;
               end
            endcase
         end

         // State register.
         always_ff @(posedge clk_sys_i or negedge nrst_sync) begin
            if (!nrst_sync) begin
               state <= LINK_OFF;
            end else begin
               state <= next_state;
            end
         end

         // Status output comes from its own flop.
         always_ff @(posedge clk_sys_i or negedge nrst_sync) begin
            if (!nrst_sync) begin
               busy_q <= FLAG_RESET;
            end else begin
               busy_q <= (next_state == LINK_BUSY);
            end
         end

         // Receive pins: flops drive value and enable directly.
         assign port_rx_dibit_o[LO +: DIBIT_WIDTH] = rx_dibit_q;
         assign port_rx_error_o[p]                 = rx_error_q;
         assign port_rx_valid_o[p]                 = rx_valid_q;
         assign port_rx_oe_o[p]                    = rx_oe_q;

         // Transmit side and status pins, driven straight from their flops.
         assign line_tx_dibit_o[LO +: DIBIT_WIDTH] = line_dibit_q;
         assign line_tx_active_o[p]                = line_active_q;
         assign port_link_busy_o[p]                = busy_q;
      end
   endgenerate

endmodule : rmii_port_interface

/* core/rmii_port_pkg.sv */
/*
 * Constants shared by the eight-port reduced media independent interface.
 * Assumes the system clock is the shared reference clock of the interface.
 */
package rmii_port_pkg;

   // Port count and width of one di-bit.
   localparam int unsigned PORT_COUNT   = 8;
   localparam int unsigned DIBIT_WIDTH  = 2;

   // Reference clock rate and the period it implies.
   localparam int unsigned REF_CLK_MHZ  = 50;
   localparam int unsigned REF_CLK_PERIOD_NS = 1000 / REF_CLK_MHZ;

   // Depth of the reset release synchroniser.
   localparam int unsigned RESET_SYNC_STAGES = 2;

   // Values held after reset.
   localparam logic [DIBIT_WIDTH-1:0] DIBIT_RESET = 2'h0;
   localparam logic                   FLAG_RESET  = 1'h0;

   // Link activity states of one port.
   typedef enum logic [2:0] {
      LINK_OFF  = 3'h1,
      LINK_IDLE = 3'h2,
      LINK_BUSY = 3'h4
   } link_state_t;

endpackage : rmii_port_pkg

/* core/rmii_reset_sync.sv */
/*
 * Reset release synchroniser: asserts at once, releases after a chain of flops.
 * Assumes an active low asynchronous reset input and one free running clock.
 */
module rmii_reset_sync #(
   parameter int unsigned STAGES = rmii_port_pkg::RESET_SYNC_STAGES
) (
   input  wire logic clk_i,
   input  wire logic nrst_i,
   output logic      nrst_sync_o
);
   import rmii_port_pkg::*;

   logic [STAGES-1:0] chain;

   // Shift ones in after release; the last stage alone is used.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         chain <= '0;
      end else begin
         chain <= {chain[STAGES-2:0], 1'b1};
      end
   end

   assign nrst_sync_o = chain[STAGES-1];

endmodule : rmii_reset_sync

/* dv/mac_stream_model.sv */
/* Controller model: streams one di-bit per port every clock while asked to send.
   Assumes its clock is the reference clock of the interface. */
module mac_stream_model (
   input  wire logic        clk_i,
   input  wire logic        send_i,
   output logic      [15:0] dibit_o,
   output logic      [7:0]  enable_o
);
   timeunit 1ns;
   timeprecision 100ps;

   logic go;

   // Lines start quiet; when idle the data lines keep toggling so stale values never look valid.
   // The send request is taken at the edge itself, so a request raised just after it never races.
   initial dibit_o = 16'h0;
   initial enable_o = 8'h0;
   always @(posedge clk_i) begin
      go = send_i;
      #1;
      enable_o <= {8{go}};
      dibit_o  <= go ? dibit_o + 16'h2D59 : ~dibit_o;
   end
endmodule : mac_stream_model

/* dv/rmii_port_chk.sv */
/* Concurrent checks on transmit capture, receive launch, float and carrier-sense timing.
   Assumes it is bound to the top module and that reset is held for several clock edges. */
module rmii_port_chk #(
   parameter int unsigned NUM_PORTS = rmii_port_pkg::PORT_COUNT,
   parameter int unsigned W         = NUM_PORTS*rmii_port_pkg::DIBIT_WIDTH
) (
   input wire logic                 clk_sys_i,
   input wire logic                 nrst_i,
   input wire logic                 isolate_i,
   input wire logic                 power_down_i,
   input wire logic [W-1:0]         port_tx_dibit_i,
   input wire logic [NUM_PORTS-1:0] port_tx_enable_i,
   input wire logic [W-1:0]         line_tx_dibit_o,
   input wire logic [NUM_PORTS-1:0] line_tx_active_o,
   input wire logic [W-1:0]         line_rx_dibit_i,
   input wire logic [NUM_PORTS-1:0] line_rx_carrier_i,
   input wire logic [W-1:0]         port_rx_dibit_o,
   input wire logic [NUM_PORTS-1:0] port_rx_valid_o,
   input wire logic [NUM_PORTS-1:0] port_rx_oe_o
);
   import rmii_port_pkg::*;

   // Counts edges after reset, so checks wait until the synchronised reset has let go.
   logic [2:0] up;
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) up <= 3'h0;
      else if (up != 3'h4) up <= up + 3'h1;
   end

   // Checks use the rising edge unless a property names the falling edge.
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (up != 3'h4);
   sequence s_no_carrier;
      line_rx_carrier_i == '0 ##1 line_rx_carrier_i == '0;
   endsequence

   // The line side shows a captured di-bit one edge after capture, two edges after the pins.
   a_tx_active_follows:
      assert property (line_tx_active_o == ($past(port_tx_enable_i, 2) & {NUM_PORTS{!$past(power_down_i, 2)}}))
      else $error("Transmit active does not follow the enable.");
   a_tx_data_follows:
      assert property (&$past(port_tx_enable_i, 2) && !$past(power_down_i, 2)
                       |-> line_tx_dibit_o == $past(port_tx_dibit_i, 2))
      else $error("Transmit di-bits do not follow the input.");
   // Modes taken at one rising edge set the enables at the falling edge before the next one.
   a_rx_float_mode:
      assert property (port_rx_oe_o == {NUM_PORTS{!($past(isolate_i) || $past(power_down_i))}})
      else $error("Receive enable wrong for the mode.");
   a_rx_float_reset:
      assert property (@(negedge clk_sys_i) disable iff (1'b0) !nrst_i && !$past(nrst_i) |-> port_rx_oe_o == '0)
      else $error("Receive pins driven during reset.");
   a_valid_at_once:
      assert property ((line_rx_carrier_i & ~port_rx_valid_o) == '0)
      else $error("Carrier present without valid.");
   a_valid_drops:
      assert property (@(negedge clk_sys_i) s_no_carrier |-> port_rx_valid_o == '0)
      else $error("Valid held after carrier loss.");
   a_rx_data_launch:
      assert property (@(negedge clk_sys_i) &$past(line_rx_carrier_i) |-> port_rx_dibit_o == $past(line_rx_dibit_i))
      else $error("Receive di-bits not launched.");
endmodule : rmii_port_chk

////////////////////////////////////////////////////////////////////////////////
bind rmii_port_interface rmii_port_chk #(.NUM_PORTS(NUM_PORTS)) chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
   .isolate_i(isolate_i), .power_down_i(power_down_i), .port_tx_dibit_i(port_tx_dibit_i),
   .port_tx_enable_i(port_tx_enable_i), .line_tx_dibit_o(line_tx_dibit_o), .line_tx_active_o(line_tx_active_o),
   .line_rx_dibit_i(line_rx_dibit_i), .line_rx_carrier_i(line_rx_carrier_i), .port_rx_dibit_o(port_rx_dibit_o),
   .port_rx_valid_o(port_rx_valid_o), .port_rx_oe_o(port_rx_oe_o));

/* dv/rmii_port_interface_tb.sv */
/* Bench for the port interface: controller model, line stimulus and mode pins.
   Assumes the design package and the checker are compiled first. */
module rmii_port_interface_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import rmii_port_pkg::*;

   logic        clk_sys_i = 1'b0, nrst_i = 1'b1, isolate_i = 1'b0, power_down_i = 1'b0, send = 1'b0;
   logic [15:0] tx_d, line_tx_dibit_o, port_rx_dibit_o, line_rx_dibit_i = 16'h0;
   logic [7:0]  tx_en, line_tx_active_o, port_rx_valid_o, port_rx_error_o, port_rx_oe_o, busy;
   logic [7:0]  line_rx_carrier_i = 8'h0, line_rx_error_i = 8'h0;
   int          bad_count = 0, total_checks = 0, cycles = 0;

   // Reference clock, running without pause.
   always #20 clk_sys_i = ~clk_sys_i;

   // Design and the controller model that feeds its transmit side.
   rmii_port_interface dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .isolate_i(isolate_i),
      .power_down_i(power_down_i), .port_tx_dibit_i(tx_d), .port_tx_enable_i(tx_en),
      .line_tx_dibit_o(line_tx_dibit_o), .line_tx_active_o(line_tx_active_o), .line_rx_dibit_i(line_rx_dibit_i),
      .line_rx_carrier_i(line_rx_carrier_i), .line_rx_error_i(line_rx_error_i), .port_rx_dibit_o(port_rx_dibit_o),
      .port_rx_valid_o(port_rx_valid_o), .port_rx_error_o(port_rx_error_o), .port_rx_oe_o(port_rx_oe_o),
      .port_link_busy_o(busy));
   mac_stream_model mac (.clk_i(clk_sys_i), .send_i(send), .dibit_o(tx_d), .enable_o(tx_en));

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t %s", $time, what);
      end
   endtask : cmp

   function automatic logic [15:0] mask(input logic [15:0] d, input logic [7:0] e);
      for (int p = 0; p < 8; p++) if (!e[p]) d[2*p+:2] = 2'h0;
      return d;
   endfunction : mask

   // Holds reset for ten clocks; the receive pins must float at once.
   task automatic do_reset;
      nrst_i = 1'b0;
      #1;
      cmp({8'h0, port_rx_oe_o}, 16'h0, "rx driven in reset");
      repeat (10) @(posedge clk_sys_i);
      #1;
      nrst_i = 1'b1;
      repeat (4) @(posedge clk_sys_i);
      #1;
      $display("reset done");
   endtask : do_reset

   // Streams di-bits; the line side shows what an edge captured just after the next edge.
   // Power-down blocks all and keeps the port from reporting activity.
   task automatic tx_stream(input logic pd);
      logic [15:0] d, nd;
      logic [7:0]  e, ne;
      power_down_i = pd;
      send = 1'b1;
      @(posedge clk_sys_i);
      d = tx_d;
      e = tx_en & {8{~power_down_i}};
      repeat (10) begin
         @(posedge clk_sys_i);
         nd = tx_d;
         ne = tx_en & {8{~power_down_i}};
         #1;
         cmp({8'h0, line_tx_active_o}, {8'h0, e}, "tx active");
         cmp(line_tx_dibit_o, mask(d, e), "tx data");
         cmp({8'h0, busy}, {8'h0, e}, "link busy");
         d = nd;
         e = ne;
      end
      @(negedge clk_sys_i);
      #1;
      cmp({8'h0, port_rx_oe_o}, {8'h0, {8{~pd}}}, "rx enable in power mode");
      @(posedge clk_sys_i);
      #1;
      send = 1'b0;
      power_down_i = 1'b0;
      @(posedge clk_sys_i);
      #1;
      $display("tx stream done");
   endtask : tx_stream

   // Isolation floats the receive pins from the falling edge after the capturing edge.
   task automatic isolate_check;
      isolate_i = 1'b1;
      @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      #1;
      cmp({8'h0, port_rx_oe_o}, 16'h0, "rx driven in isolation");
      @(posedge clk_sys_i);
      #1;
      isolate_i = 1'b0;
      @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      #1;
      cmp({8'h0, port_rx_oe_o}, 16'h00FF, "rx not driven");
      @(posedge clk_sys_i);
      #1;
      $display("isolate done");
   endtask : isolate_check

   // Carrier raises valid at once; data waits for the falling edge; loss clears it there.
   task automatic rx_check;
      line_rx_carrier_i = 8'hFF;
      line_rx_dibit_i = 16'hA5C3;
      line_rx_error_i = 8'h0F;
      #1;
      cmp({8'h0, port_rx_valid_o}, 16'h00FF, "valid late");
      cmp(port_rx_dibit_o, 16'h0, "rx data early");
      @(negedge clk_sys_i);
      #1;
      cmp(port_rx_dibit_o, 16'hA5C3, "rx data");
      cmp({8'h0, port_rx_error_o}, 16'h000F, "rx error");
      @(posedge clk_sys_i);
      #1;
      line_rx_carrier_i = 8'h0;
      line_rx_error_i = 8'hF0;
      #1;
      cmp({8'h0, port_rx_valid_o}, 16'h00FF, "valid dropped early");
      @(negedge clk_sys_i);
      #1;
      cmp({8'h0, port_rx_valid_o}, 16'h0, "valid held");
      cmp(port_rx_dibit_o, 16'h0, "rx data idle");
      cmp({8'h0, port_rx_error_o}, 16'h0, "error outside carrier");
      @(posedge clk_sys_i);
      #1;
      line_rx_error_i = 8'h0;
      line_rx_dibit_i = 16'h0;
      $display("rx done");
   endtask : rx_check

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test

   // Cuts a hang short well beyond the expected run length.
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 2000) begin
         bad_count++;
         end_of_test();
      end
   end

   // Main sequence, with a second reset in mid-run.
   initial begin
      #1;
      do_reset();
      tx_stream(1'b0);
      tx_stream(1'b1);
      isolate_check();
      rx_check();
      do_reset();
      tx_stream(1'b0);
      end_of_test();
   end
endmodule : rmii_port_interface_tb
